// ==== verilog/lcdcd_decoder.sv ====
`timescale 1ns/1ps
`include "lcdcd_defines.svh"
module lcdcd_decoder (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic       command_data_select_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic      [4:0] start_line_o,
    output logic            disp_on_o,
    output logic            static_on_o,
    output logic            duty_32_o,
    output logic            seg_normal_o,
    output logic            power_save_o,
    output logic            busy_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // select and data are held stable around the strobe, so sampling
    // them at the synchronised strobe edge is safe
    lcdcd_pkg::lcdcd_state_t s_q;
    lcdcd_pkg::lcdcd_state_t s_d;
    logic [1:0] sel_s_q;
    logic [7:0] dat_a_q;
    logic [7:0] dat_b_q;
    logic       data_oe_q;
    logic [7:0] data_q;
    logic       psave_q;

    always_ff @(posedge clk_sys_i) begin
        sel_s_q <= {sel_s_q[0], command_data_select_i};
        dat_a_q <= data_i;
        dat_b_q <= dat_a_q;
    end

    // ------------------------------------------------------------
    // cycle classification
    // ------------------------------------------------------------
    logic rd_fall;
    logic wr_rise;
    logic rd_act;
    lcdcd_pkg::lcdcd_cyc_t cyc;
    assign rd_fall = s_q.rd_s[2] & ~s_q.rd_s[1];
    assign wr_rise = ~s_q.wr_s[2] & s_q.wr_s[1];
    assign rd_act  = ~s_q.rd_s[1];
    assign cyc = lcdcd_pkg::lcdcd_cyc_t'({sel_s_q[1], rd_act});

    // ------------------------------------------------------------
    // display ram
    // ------------------------------------------------------------
    logic       ram_we;
    logic [8:0] ram_addr;
    logic [7:0] ram_q;
    // address = page*80 + column; page only steers host accesses
    assign ram_addr = 9'(({7'h00, s_q.page} * 9'h050) +
                         {2'h0, s_q.col});
    assign ram_we   = wr_rise && sel_s_q[1] &&
                      (s_q.col <= `LCDCD_COL_LAST);

    lcdcd_ram u_ram (
        .clk_sys_i (clk_sys_i),
        .we_i      (ram_we),
        .waddr_i   (ram_addr),
        .wdata_i   (dat_b_q),
        .raddr_i   (ram_addr),
        .rdata_o   (ram_q)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    function automatic logic [6:0] col_step(input logic [6:0] c);
        col_step = (c >= `LCDCD_COL_LOCK) ? c : 7'(c + 7'h01);
    endfunction

    logic [7:0] cmd;
    assign cmd = dat_b_q;

    always_comb begin
        s_d = s_q;
        s_d.rd_s = {s_q.rd_s[1:0], rd_n_i};
        s_d.wr_s = {s_q.wr_s[1:0], wr_n_i};
        s_d.busy = 1'b0;
        if (s_q.init_cnt != 4'h0) begin
            s_d.init_cnt = 4'(s_q.init_cnt - 4'h1);
            s_d.busy = 1'b1;
        end
        if (rd_fall && cyc == lcdcd_pkg::LCDCD_CYC_DRD) begin
            // bus holder: read returns latched byte, then refetch
            s_d.rd_data = ram_q;
            if (!s_q.rmw) begin
                s_d.col = col_step(s_q.col);
            end
        end
        if (wr_rise && sel_s_q[1]) begin
            s_d.col = col_step(s_q.col);
        end
        if (wr_rise && !sel_s_q[1]) begin
            s_d.busy = 1'b1;
            if (!cmd[7]) begin
                s_d.col = cmd[6:0];
            end else if (cmd[7:2] == `LCDCD_PFX_PAGE) begin
                s_d.page = cmd[1:0];
            end else if (cmd[7:5] == `LCDCD_PFX_LINE) begin
                s_d.start_line = cmd[4:0];
            end else if (cmd[7:1] == `LCDCD_PFX_SEG) begin
                s_d.seg_normal = cmd[0];
            end else if (cmd[7:1] == `LCDCD_PFX_STAT) begin
                s_d.static_on = cmd[0];
            end else if (cmd[7:1] == `LCDCD_PFX_DUTY) begin
                s_d.duty_32 = cmd[0];
            end else if (cmd[7:1] == `LCDCD_PFX_DISP) begin
                s_d.disp_on = cmd[0];
            end else if (cmd == `LCDCD_CMD_RMW) begin
                s_d.rmw = 1'b1;
                s_d.col_save = s_q.col;
            end else if (cmd == `LCDCD_CMD_END) begin
                s_d.rmw = 1'b0;
                s_d.col = s_q.col_save;
            end else if (cmd == `LCDCD_CMD_RESET) begin
                s_d.start_line = `LCDCD_LINE_RST;
                s_d.page = `LCDCD_PAGE_RST;
                s_d.init_cnt = `LCDCD_INIT_CYC;
            end
            // anything else leaves state alone apart from busy
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s_q <= '0;
            s_q.rd_s <= 3'h7;
            s_q.wr_s <= 3'h7;
            s_q.page <= `LCDCD_PAGE_RST;
            s_q.col <= `LCDCD_COL_RST;
            s_q.start_line <= `LCDCD_LINE_RST;
            s_q.duty_32 <= `LCDCD_DUTY_RST;
            s_q.seg_normal <= `LCDCD_SEG_RST;
            s_q.init_cnt <= `LCDCD_INIT_CYC;
            s_q.busy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // status and outputs
    // ------------------------------------------------------------
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[`LCDCD_ST_BUSY] = s_q.busy;
        status[`LCDCD_ST_SEG]  = s_q.seg_normal;
        status[`LCDCD_ST_OFF]  = ~s_q.disp_on;
        status[`LCDCD_ST_INIT] = (s_q.init_cnt != 4'h0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            data_q    <= 8'h00;
            data_oe_q <= 1'b0;
            psave_q   <= 1'b0;
        end else begin
            data_oe_q <= rd_act;
            if (rd_fall) begin
                data_q <= sel_s_q[1] ? s_q.rd_data : status;
            end
            psave_q <= ~s_d.disp_on & s_d.static_on;
        end
    end

    assign data_o       = data_q;
    assign data_oe_o    = data_oe_q;
    assign start_line_o = s_q.start_line;
    assign disp_on_o    = s_q.disp_on;
    assign static_on_o  = s_q.static_on;
    assign duty_32_o    = s_q.duty_32;
    assign seg_normal_o = s_q.seg_normal;
    assign power_save_o = psave_q;
    assign busy_o       = s_q.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_col_lock;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (s_q.col == `LCDCD_COL_LOCK && wr_rise && sel_s_q[1])
            |=> s_q.col == `LCDCD_COL_LOCK;
    endproperty
    a_col_lock: assert property (p_col_lock)
        else $error("column moved past lock");

    property p_wr_inc;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && sel_s_q[1] && s_q.col < `LCDCD_COL_LOCK)
            |=> s_q.col == $past(s_q.col) + 7'h01 &&
                s_q.page == $past(s_q.page);
    endproperty
    a_wr_inc: assert property (p_wr_inc)
        else $error("data write did not step column");

    property p_rmw_rd;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_fall && sel_s_q[1] && s_q.rmw) |=> $stable(s_q.col);
    endproperty
    a_rmw_rd: assert property (p_rmw_rd)
        else $error("rmw read moved column");

    property p_end_restore;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && cmd == `LCDCD_CMD_END)
            |=> !s_q.rmw && s_q.col == $past(s_q.col_save);
    endproperty
    a_end_restore: assert property (p_end_restore)
        else $error("end did not restore column");

    property p_reset_cmd;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && cmd == `LCDCD_CMD_RESET)
            |=> s_q.page == `LCDCD_PAGE_RST &&
                s_q.start_line == `LCDCD_LINE_RST ##1 status[4];
    endproperty
    a_reset_cmd: assert property (p_reset_cmd)
        else $error("reset command result wrong");

    property p_psave;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        power_save_o == (~s_q.disp_on & s_q.static_on);
    endproperty
    a_psave: assert property (p_psave)
        else $error("power save state wrong");

    property p_off_flag;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_fall && !sel_s_q[1]) |=> data_o[5] == ~disp_on_o &&
            data_o[3:0] == 4'h0 && data_o[6] == seg_normal_o;
    endproperty
    a_off_flag: assert property (p_off_flag)
        else $error("status byte wrong");

    property p_page_set;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && cmd[7:2] == `LCDCD_PFX_PAGE)
            |=> s_q.page == $past(cmd[1:0]) && $stable(s_q.start_line);
    endproperty
    a_page_set: assert property (p_page_set)
        else $error("page set failed");

    property p_col_set;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && !cmd[7])
            |=> {1'b0, s_q.col} == $past(cmd) && $stable(s_q.page);
    endproperty
    a_col_set: assert property (p_col_set)
        else $error("column set failed");

    property p_rd_inc;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_fall && sel_s_q[1] && !s_q.rmw && s_q.col < `LCDCD_COL_LOCK)
            |=> s_q.col == $past(s_q.col) + 7'h01 && $stable(s_q.page);
    endproperty
    a_rd_inc: assert property (p_rd_inc)
        else $error("data read did not step column");

    property p_status_busy;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_fall && !sel_s_q[1]) |=> data_o[7] == $past(busy_o) &&
            data_o[4] == ($past(s_q.init_cnt) != 4'h0);
    endproperty
    a_status_busy: assert property (p_status_busy)
        else $error("status busy or init bit wrong");

    property p_disp_set;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && cmd[7:1] == `LCDCD_PFX_DISP)
            |=> disp_on_o == $past(cmd[0]) && $stable(s_q.static_on);
    endproperty
    a_disp_set: assert property (p_disp_set)
        else $error("display on/off failed");

    property p_unmatched;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_rise && !sel_s_q[1] && cmd[7] &&
         cmd[7:2] != `LCDCD_PFX_PAGE && cmd[7:5] != `LCDCD_PFX_LINE &&
         cmd[7:1] != `LCDCD_PFX_SEG && cmd[7:1] != `LCDCD_PFX_STAT &&
         cmd[7:1] != `LCDCD_PFX_DUTY && cmd[7:1] != `LCDCD_PFX_DISP &&
         cmd != `LCDCD_CMD_RMW && cmd != `LCDCD_CMD_END &&
         cmd != `LCDCD_CMD_RESET)
            |=> $stable(s_q.col) && $stable(s_q.page) && $stable(s_q.rmw) &&
                $stable(s_q.start_line) && $stable(s_q.disp_on) &&
                $stable(s_q.static_on) && $stable(s_q.duty_32) &&
                $stable(s_q.seg_normal);
    endproperty
    a_unmatched: assert property (p_unmatched)
        else $error("unmatched command changed state");

    c_rmw: cover property (@(posedge clk_sys_i) s_q.rmw ##[1:50] !s_q.rmw);
    c_rmw_rd: cover property (@(posedge clk_sys_i)
        rd_fall && sel_s_q[1] && s_q.rmw);
    c_lock: cover property (@(posedge clk_sys_i)
        s_q.col == `LCDCD_COL_LOCK);
    c_psave: cover property (@(posedge clk_sys_i) power_save_o);
endmodule // lcdcd_decoder

// ==== include/lcdcd_defines.svh ====
`ifndef LCDCD_DEFINES_SVH
`define LCDCD_DEFINES_SVH
// Notes on behaviour
// - command 101110pp selects ram page 0..3 for later accesses
// - page change never alters the shown image; page steers host only
// - command with bit7 clear loads column counter; valid 0..4f
// - column steps by one per access except rmw reads, locks at 50; page unchanged
// - status read: busy b7, segment order b6, display off b5, init b4
// - segment order flag 1 normal mapping, 0 inverse mapping
// - display state flag reads 0 on, 1 off; inverse of written bit
// - init flag reads 1 during pin reset or reset instruction
// - data write stores byte at page/column then increments column
// - data read returns byte, increments column unless in rmw mode
// - command 1010000x sets segment order from bit 0
// - command 1010010x: bit0 1 static drive on, 0 normal
// - command 1010100x: bit0 0 selects 1/16 duty, 1 selects 1/32
// - command e0 enters rmw: writes increment, reads hold column
// - command ee leaves rmw and restores column saved at entry
// - command e2 sets start line 0 and page 3; ram untouched
// - display off with static drive on enters power save
// - display on or static drive off leaves power save
// - command 1010111x: bit0 1 display on, 0 display off
// - command 110lllll sets 5-bit display start line
// - cycle kind from select and strobe: data/status/command

`define LCDCD_COL_LAST     7'h4f
`define LCDCD_COL_LOCK     7'h50
`define LCDCD_PAGE_RST     2'h3
`define LCDCD_LINE_RST     5'h00
`define LCDCD_COL_RST      7'h00
`define LCDCD_DUTY_RST     1'b1
`define LCDCD_SEG_RST      1'b0
`define LCDCD_INIT_CYC     4'h4
`define LCDCD_ST_BUSY      7
`define LCDCD_ST_SEG       6
`define LCDCD_ST_OFF       5
`define LCDCD_ST_INIT      4
`define LCDCD_CMD_RMW      8'he0
`define LCDCD_CMD_END      8'hee
`define LCDCD_CMD_RESET    8'he2
`define LCDCD_PFX_PAGE     6'h2e
`define LCDCD_PFX_LINE     3'h6
`define LCDCD_PFX_SEG      7'h50
`define LCDCD_PFX_STAT     7'h52
`define LCDCD_PFX_DUTY     7'h54
`define LCDCD_PFX_DISP     7'h57
`endif

// ==== include/lcdcd_pkg.sv ====
package lcdcd_pkg;
    typedef enum logic [1:0] {
        LCDCD_CYC_DRD = 2'h3,
        LCDCD_CYC_DWR = 2'h2,
        LCDCD_CYC_STS = 2'h1,
        LCDCD_CYC_CMD = 2'h0
    } lcdcd_cyc_t;

    typedef struct packed {
        logic [2:0] rd_s;
        logic [2:0] wr_s;
        logic [7:0] rd_data;
        logic [1:0] page;
        logic [6:0] col;
        logic [6:0] col_save;
        logic [4:0] start_line;
        logic       disp_on;
        logic       static_on;
        logic       duty_32;
        logic       seg_normal;
        logic       rmw;
        logic [3:0] init_cnt;
        logic       busy;
    } lcdcd_state_t;
endpackage

// ==== verilog/lcdcd_ram.sv ====
`timescale 1ns/1ps
module lcdcd_ram (
    input  wire logic       clk_sys_i,
    input  wire logic       we_i,
    input  wire logic [8:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [8:0] raddr_i,
    output logic      [7:0] rdata_o
);
    // 4 pages x 80 columns; indices past 319 never written
    logic [7:0] mem [0:511];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // lcdcd_ram

// ==== sim/lcdcd_host_model.sv ====
`timescale 1ns/1ps
module lcdcd_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_oe_i,
    output logic            command_data_select_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic      [7:0] wdata_o
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    initial begin
        command_data_select_o = 1'b0;
        rd_n_o                = 1'b1;
        wr_n_o                = 1'b1;
        wdata_o               = 8'h5a;
    end

    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    // spacing far above the busy time of most commands, so no status poll is needed; busy after e2 outlasts it
    task automatic gap(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask

    // data held past the release: the strobe sync lags the data path
    task automatic write(input logic sel, input logic [7:0] d);
        command_data_select_o = sel;
        wdata_o               = d;
        wr_n_o                = 1'b0;
        gap(6);
        wr_n_o                = 1'b1;
        gap(3);
        wdata_o               = ~d;
        gap(3);
    endtask

    task automatic read(input logic sel, output logic [7:0] d,
                        output logic oe);
        command_data_select_o = sel;
        rd_n_o                = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        d                     = rdata_i;
        oe                    = rdata_oe_i;
        #2;
        rd_n_o                = 1'b1;
        gap(6);
    endtask
endmodule // lcdcd_host_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic       clk_sys_i;
    logic       nrst_i;
    logic       sel;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] wdata;
    logic [7:0] data_o;
    logic       data_oe_o;
    logic [4:0] start_line_o;
    logic       disp_on_o;
    logic       static_on_o;
    logic       duty_32_o;
    logic       seg_normal_o;
    logic       power_save_o;
    logic       busy_o;
    int         n_mismatch;
    int         check_count;
    int         i;

    lcdcd_decoder lcdcd_decoder_inst (
        .clk_sys_i             (clk_sys_i),
        .nrst_i                (nrst_i),
        .command_data_select_i (sel),
        .rd_n_i                (rd_n),
        .wr_n_i                (wr_n),
        .data_i                (wdata),
        .data_o                (data_o),
        .data_oe_o             (data_oe_o),
        .start_line_o          (start_line_o),
        .disp_on_o             (disp_on_o),
        .static_on_o           (static_on_o),
        .duty_32_o             (duty_32_o),
        .seg_normal_o          (seg_normal_o),
        .power_save_o          (power_save_o),
        .busy_o                (busy_o)
    );

    lcdcd_host_model lcdcd_host_model_inst (
        .clk_sys_i             (clk_sys_i),
        .rdata_i               (data_o),
        .rdata_oe_i            (data_oe_o),
        .command_data_select_o (sel),
        .rd_n_o                (rd_n),
        .wr_n_o                (wr_n),
        .wdata_o               (wdata)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        lcdcd_host_model_inst.write(1'b0, b);
    endtask

    task automatic dwr(input logic [7:0] b);
        lcdcd_host_model_inst.write(1'b1, b);
    endtask

    task automatic rd(input logic s, input logic [7:0] e);
        logic [7:0] d;
        logic       oe;
        lcdcd_host_model_inst.read(s, d, oe);
        chk(16'(d), 16'(e));
        chk(16'(oe), 16'h0001);
        chk(16'(data_oe_o), 16'h0000);
    endtask

    // first read after addressing only refills the holder
    task automatic dummy();
        logic [7:0] d;
        logic       oe;
        lcdcd_host_model_inst.read(1'b1, d, oe);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_mismatch++;
        final_report();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        n_mismatch  = 0;
        check_count = 0;
        nrst_i      = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #2 nrst_i = 1'b1;
        @(posedge clk_sys_i);
        #2 chk(16'(busy_o), 16'h0001);
        for (i = 0; i < 20 && busy_o !== 1'b0; i++) begin
            @(posedge clk_sys_i);
            #2;
        end
        chk(16'(busy_o), 16'h0000);
        chk(16'({start_line_o, disp_on_o, static_on_o, duty_32_o}),
            16'h0001);
        rd(1'b0, 8'h20);
        cmd(8'ha1);
        cmd(8'haf);
        rd(1'b0, 8'h40);
        for (i = 0; i < 2; i++) begin
            cmd(8'ha0 | 8'(i));
            cmd(8'ha4 | 8'(i));
            cmd(8'ha8 | 8'(i));
            cmd(8'hae | 8'(i));
            chk(16'({seg_normal_o, static_on_o, duty_32_o, disp_on_o}),
                16'(i * 15));
            chk(16'(power_save_o), 16'h0000);
        end
        cmd(8'hae);
        chk(16'(power_save_o), 16'h0001);
        cmd(8'haf);
        chk(16'(power_save_o), 16'h0000);
        cmd(8'hae);
        cmd(8'ha4);
        chk(16'(power_save_o), 16'h0000);
        cmd(8'hd5);
        chk(16'(start_line_o), 16'h0015);
        cmd(8'hf0);
        cmd(8'hbf);
        cmd(8'hff);
        chk(16'({start_line_o, disp_on_o, static_on_o, duty_32_o,
                 seg_normal_o, power_save_o}), 16'h02a6);
        rd(1'b0, 8'h60);
        // ram: page select, auto increment and the lock at the end
        cmd(8'hbb);
        cmd(8'h00);
        dwr(8'h3c);
        cmd(8'hba);
        cmd(8'h00);
        dwr(8'hc3);
        cmd(8'hb9);
        chk(16'(start_line_o), 16'h0015);
        cmd(8'h00);
        dwr(8'h77);
        cmd(8'h4e);
        dwr(8'ha1);
        dwr(8'ha2);
        dwr(8'ha3);
        dwr(8'ha4);
        cmd(8'hb8);
        cmd(8'h4e);
        dwr(8'h5c);
        cmd(8'hb9);
        cmd(8'h4e);
        dummy();
        rd(1'b1, 8'ha1);
        rd(1'b1, 8'ha2);
        cmd(8'h00);
        dummy();
        rd(1'b1, 8'h77);
        // writes held at the lock must not spill into the next page
        cmd(8'hba);
        cmd(8'h00);
        dummy();
        rd(1'b1, 8'hc3);
        // read-modify-write holds the column on reads
        cmd(8'h10);
        dwr(8'h11);
        dwr(8'h12);
        cmd(8'h10);
        cmd(8'he0);
        dummy();
        rd(1'b1, 8'h11);
        rd(1'b1, 8'h11);
        dwr(8'h99);
        cmd(8'hee);
        dummy();
        rd(1'b1, 8'h99);
        rd(1'b1, 8'h12);
        // reset instruction: line 0 and page 3, other settings kept
        cmd(8'he2);
        chk(16'(busy_o), 16'h0001);
        chk(16'(start_line_o), 16'h0000);
        chk(16'({disp_on_o, static_on_o, duty_32_o, seg_normal_o}),
            16'h0003);
        repeat (4) @(posedge clk_sys_i);
        #2 chk(16'(busy_o), 16'h0000);
        cmd(8'h00);
        dummy();
        rd(1'b1, 8'h3c);
        final_report();
    end
endmodule // testbench
